/* File: src/oas_pkg.sv */
// shared constants, types and register map of the operand address and stack unit
package oas_pkg;

  // =====================================================================
  // register map (printed offsets are indices; byte address is index * 4)
  localparam logic [7:0]  IDX_SLICE_FIRST  = 8'hd6;
  localparam logic [7:0]  IDX_SLICE_SECOND = 8'hd7;
  localparam logic [7:0]  IDX_STACK_HIGH   = 8'hd8;
  localparam logic [7:0]  IDX_STACK_LOW    = 8'hd9;
  localparam int          APB_AW           = 12;

  // =====================================================================
  // field layout and reset values
  localparam logic [3:0]  WR_PREFIX        = 4'hc;
  localparam int          WR_SEL_BIT       = 3;
  localparam int          SLICE_LSB        = 3;
  localparam logic [4:0]  SLICE_FIRST_RST  = 5'h18;
  localparam logic [4:0]  SLICE_SECOND_RST = 5'h19;
  localparam logic [7:0]  UPPER_SET_BASE   = 8'hc0;
  localparam logic [1:0]  CNT_ONE          = 2'h1;
  localparam logic [1:0]  CNT_TWO          = 2'h2;
  localparam logic [1:0]  CNT_THREE        = 2'h3;

  // =====================================================================
  // enumerations
  typedef enum logic [2:0] {
    CMD_EA, CMD_PUSH, CMD_POP, CMD_CALL, CMD_RET, CMD_INTR, CMD_INT_RET
  } oas_cmd_t;

  typedef enum logic [3:0] {
    MD_REG, MD_REG_IND, MD_PAIR_IND, MD_IDX_REG, MD_IDX_LONG, MD_IDX_SHORT,
    MD_ABS, MD_MEM_IND, MD_REL, MD_IMM_BYTE, MD_IMM_WORD
  } oas_mode_t;

  typedef enum logic [2:0] {
    SPC_REG_SET1, SPC_REG_SET2, SPC_PROG, SPC_EXT, SPC_VALUE
  } oas_space_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH_WAIT, ST_FETCH_CAP, ST_PUSH, ST_POP_RD, ST_POP_WAIT, ST_POP_CAP
  } oas_state_t;

  // =====================================================================
  // carriers
  typedef struct packed {
    oas_cmd_t    cmd;
    oas_mode_t   mode;
    logic        ext;
    logic [7:0]  opnd;
    logic [15:0] word;
    logic [15:0] base;
    logic [7:0]  data;
    logic [15:0] pc;
    logic [7:0]  flags;
  } oas_req_t;

  typedef struct packed {
    logic        valid;
    oas_space_t  space;
    logic [15:0] addr;
    logic [15:0] value;
    logic        pc_load;
    logic [15:0] pc;
    logic        flags_load;
    logic [7:0]  flags;
    logic        data_load;
    logic [7:0]  data;
  } oas_res_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } oas_stk_t;

  typedef struct packed {
    logic        re;
    logic [15:0] addr;
  } oas_pm_t;

endpackage

/* File: src/oas_addr_unit.sv */
// operand address generation, working register decode and system stack engine
//
// Notes on behaviour
// - upper nibble 1100 means working register
// - bit 3 picks pointer; five plus three bits
// - call pushes pc, return pops it
// - interrupt pushes pc and flags; return pops
// - decrement before push, increment after pop
// - sixteen-bit pointer split high/low registers
// - stack pointer has no reset value
// - low byte wrap carries into high byte
// - indirect: register contents form operand address
// - indirect never reaches upper set one
// - indexed never reaches upper set one
// - register index: base plus working offset
// - memory index: pair base plus offset
// - short memory offset is sign extended
// - indexed register form only via load
// - absolute mode carries full sixteen bits
// - memory indirect: zero-extend, fetch byte pair
// - relative: next pc plus signed byte
// - immediate value from operand field
// - reset pointers select common block C0H-CFH
//
// Decided for this implementation: the APB interface to the registers.
module oas_addr_unit (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_req_valid,
  input  wire oas_pkg::oas_req_t     i_req,
  output logic                       o_req_ready,
  output oas_pkg::oas_res_t          o_res,
  output oas_pkg::oas_stk_t          o_stk,
  input  wire logic [7:0]            i_stk_rdata,
  output oas_pkg::oas_pm_t           o_pm,
  input  wire logic [7:0]            i_pm_rdata
);
  import oas_pkg::*;

  // =====================================================================
  // declarations
  localparam logic [11:0] ADDR_SLICE_FIRST  = {2'b00, IDX_SLICE_FIRST, 2'b00};
  localparam logic [11:0] ADDR_SLICE_SECOND = {2'b00, IDX_SLICE_SECOND, 2'b00};
  localparam logic [11:0] ADDR_STACK_HIGH   = {2'b00, IDX_STACK_HIGH, 2'b00};
  localparam logic [11:0] ADDR_STACK_LOW    = {2'b00, IDX_STACK_LOW, 2'b00};

  logic [4:0]  slice_pointer_first;
  logic [4:0]  slice_pointer_second;
  logic [7:0]  stack_pointer_high;
  logic [7:0]  stack_pointer_low;
  logic [15:0] sp_word;
  logic [15:0] sp_minus;
  logic [15:0] sp_plus;
  logic        sp_dec;
  logic        sp_inc;

  logic        apb_setup;
  logic        apb_access;
  logic        apb_hit;
  logic        apb_wr;
  logic [31:0] next_prdata;

  oas_state_t  state;
  oas_cmd_t    cur_cmd;
  logic [1:0]  cnt;
  logic [1:0]  idx;
  logic [7:0]  push_buf [3];
  logic [23:0] pop_sr;
  logic [23:0] next_pop_sr;
  logic [15:0] tgt;
  logic        fetch_lo;

  oas_space_t  ea_space;
  logic [15:0] ea_addr;
  logic [15:0] ea_value;
  logic [7:0]  ea_sum8;
  logic [3:0]  wr_nib;
  logic [4:0]  wr_slice;

  // =====================================================================
  // apb slave, pready follows i_ce, so wait states only while i_ce is low
  assign apb_setup  = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;
  assign apb_hit    = (i_paddr == ADDR_SLICE_FIRST) || (i_paddr == ADDR_SLICE_SECOND) ||
                      (i_paddr == ADDR_STACK_HIGH) || (i_paddr == ADDR_STACK_LOW);
  assign apb_wr     = apb_access & i_pwrite & apb_hit & i_ce;
  assign o_pready   = i_ce;
  assign o_pslverr  = apb_access & ~apb_hit;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (i_paddr)
      ADDR_SLICE_FIRST:  next_prdata[7:0] = {slice_pointer_first, 3'b000};
      ADDR_SLICE_SECOND: next_prdata[7:0] = {slice_pointer_second, 3'b000};
      ADDR_STACK_HIGH:   next_prdata[7:0] = stack_pointer_high;
      ADDR_STACK_LOW:    next_prdata[7:0] = stack_pointer_low;
      default:           next_prdata = 32'h0000_0000;
    endcase
  end

  // read data sampled in the setup phase so it comes from a flip-flop
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_prdata <= 32'h0000_0000;
    else if (i_ce && apb_setup && !i_pwrite)
      o_prdata <= next_prdata;
  end

  // =====================================================================
  // slice pointers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      slice_pointer_first  <= SLICE_FIRST_RST;
      slice_pointer_second <= SLICE_SECOND_RST;
    end
    else if (apb_wr && i_paddr == ADDR_SLICE_FIRST)
      slice_pointer_first <= i_pwdata[7:SLICE_LSB];
    else if (apb_wr && i_paddr == ADDR_SLICE_SECOND)
      slice_pointer_second <= i_pwdata[7:SLICE_LSB];
  end

  // =====================================================================
  // stack pointer: no reset, engine update wins over a software write
  assign sp_word  = {stack_pointer_high, stack_pointer_low};
  assign sp_minus = sp_word - 16'h0001;
  assign sp_plus  = sp_word + 16'h0001;
  assign sp_dec   = (state == ST_PUSH);
  assign sp_inc   = (state == ST_POP_RD);

  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      if (sp_dec)
        {stack_pointer_high, stack_pointer_low} <= sp_minus;
      else if (sp_inc)
        {stack_pointer_high, stack_pointer_low} <= sp_plus;
      else if (apb_wr && i_paddr == ADDR_STACK_HIGH)
        stack_pointer_high <= i_pwdata[7:0];
      else if (apb_wr && i_paddr == ADDR_STACK_LOW)
        stack_pointer_low <= i_pwdata[7:0];
    end
  end

  // =====================================================================
  // effective address
  assign wr_nib   = i_req.opnd[3:0];
  assign wr_slice = wr_nib[WR_SEL_BIT] ? slice_pointer_second : slice_pointer_first;

  always_comb
  begin
    ea_space = SPC_REG_SET1;
    ea_addr  = 16'h0000;
    ea_value = 16'h0000;
    ea_sum8  = i_req.opnd + i_req.data;
    unique case (i_req.mode)
      MD_REG:
      begin
        if (i_req.opnd[7:4] == WR_PREFIX)
          ea_addr = {8'h00, wr_slice, wr_nib[2:0]};
        else
          ea_addr = {8'h00, i_req.opnd};
      end
      MD_REG_IND:
      begin
        ea_addr  = {8'h00, i_req.data};
        ea_space = (i_req.data >= UPPER_SET_BASE) ? SPC_REG_SET2 : SPC_REG_SET1;
      end
      MD_PAIR_IND:
      begin
        ea_addr  = i_req.base;
        ea_space = i_req.ext ? SPC_EXT : SPC_PROG;
      end
      MD_IDX_REG:
      begin
        ea_addr  = {8'h00, ea_sum8};
        ea_space = (ea_sum8 >= UPPER_SET_BASE) ? SPC_REG_SET2 : SPC_REG_SET1;
      end
      MD_IDX_LONG:
      begin
        ea_addr  = i_req.base + i_req.word;
        ea_space = i_req.ext ? SPC_EXT : SPC_PROG;
      end
      MD_IDX_SHORT:
      begin
        ea_addr  = i_req.base + {{8{i_req.opnd[7]}}, i_req.opnd};
        ea_space = i_req.ext ? SPC_EXT : SPC_PROG;
      end
      MD_ABS:
      begin
        ea_addr  = i_req.word;
        ea_space = i_req.ext ? SPC_EXT : SPC_PROG;
      end
      MD_MEM_IND:
      begin
        ea_addr  = {8'h00, i_req.opnd};
        ea_space = SPC_PROG;
      end
      MD_REL:
      begin
        ea_addr  = i_req.pc + {{8{i_req.opnd[7]}}, i_req.opnd};
        ea_space = SPC_PROG;
      end
      MD_IMM_BYTE:
      begin
        ea_value = {8'h00, i_req.opnd};
        ea_space = SPC_VALUE;
      end
      MD_IMM_WORD:
      begin
        ea_value = i_req.word;
        ea_space = SPC_VALUE;
      end
      default:
      begin
        ea_space = SPC_REG_SET1;
      end
    endcase
  end

  // =====================================================================
  // command sequencer
  assign o_req_ready = (state == ST_IDLE) & i_ce;
  assign next_pop_sr = {pop_sr[15:0], i_stk_rdata};

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state       <= ST_IDLE;
      cur_cmd     <= CMD_EA;
      cnt         <= 2'h0;
      idx         <= 2'h0;
      push_buf[0] <= 8'h00;
      push_buf[1] <= 8'h00;
      push_buf[2] <= 8'h00;
      pop_sr      <= 24'h00_0000;
      tgt         <= 16'h0000;
      fetch_lo    <= 1'b0;
      o_res       <= '0;
      o_stk       <= '0;
      o_pm        <= '0;
    end
    else if (i_ce)
    begin
      o_res <= '0;
      o_stk <= '0;
      o_pm  <= '0;
      unique case (state)
        ST_IDLE:
        begin
          if (i_req_valid)
          begin
            cur_cmd     <= i_req.cmd;
            tgt         <= i_req.word;
            idx         <= 2'h0;
            push_buf[0] <= i_req.pc[7:0];
            push_buf[1] <= i_req.pc[15:8];
            push_buf[2] <= i_req.flags;
            unique case (i_req.cmd)
              CMD_EA:
              begin
                o_res.valid <= 1'b1;
                o_res.space <= ea_space;
                o_res.addr  <= ea_addr;
                o_res.value <= ea_value;
              end
              CMD_PUSH:
              begin
                push_buf[0] <= i_req.data;
                cnt         <= CNT_ONE;
                state       <= ST_PUSH;
              end
              CMD_CALL:
              begin
                cnt <= CNT_TWO;
                if (i_req.mode == MD_MEM_IND)
                begin
                  o_pm.re   <= 1'b1;
                  o_pm.addr <= {8'h00, i_req.opnd};
                  tgt       <= {8'h00, i_req.opnd};
                  fetch_lo  <= 1'b0;
                  state     <= ST_FETCH_WAIT;
                end
                else
                  state <= ST_PUSH;
              end
              CMD_INTR:
              begin
                cnt   <= CNT_THREE;
                state <= ST_PUSH;
              end
              CMD_POP:
              begin
                cnt   <= CNT_ONE;
                state <= ST_POP_RD;
              end
              CMD_RET:
              begin
                cnt   <= CNT_TWO;
                state <= ST_POP_RD;
              end
              CMD_INT_RET:
              begin
                cnt   <= CNT_THREE;
                state <= ST_POP_RD;
              end
              default:
              begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_FETCH_WAIT:
        begin
          state <= ST_FETCH_CAP;
        end
        ST_FETCH_CAP:
        begin
          if (!fetch_lo)
          begin
            // high byte at the even address, low byte follows
            o_pm.re   <= 1'b1;
            o_pm.addr <= tgt + 16'h0001;
            tgt[15:8] <= i_pm_rdata;
            fetch_lo  <= 1'b1;
            state     <= ST_FETCH_WAIT;
          end
          else
          begin
            tgt[7:0] <= i_pm_rdata;
            state    <= ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          o_stk.we    <= 1'b1;
          o_stk.addr  <= sp_minus;
          o_stk.wdata <= push_buf[idx];
          idx         <= idx + 2'h1;
          if (idx == cnt - 2'h1)
          begin
            o_res.valid   <= 1'b1;
            o_res.pc_load <= (cur_cmd != CMD_PUSH);
            o_res.pc      <= tgt;
            state         <= ST_IDLE;
          end
        end
        ST_POP_RD:
        begin
          o_stk.re   <= 1'b1;
          o_stk.addr <= sp_word;
          state      <= ST_POP_WAIT;
        end
        ST_POP_WAIT:
        begin
          state <= ST_POP_CAP;
        end
        ST_POP_CAP:
        begin
          pop_sr <= next_pop_sr;
          idx    <= idx + 2'h1;
          if (idx == cnt - 2'h1)
          begin
            o_res.valid      <= 1'b1;
            o_res.data_load  <= (cur_cmd == CMD_POP);
            o_res.data       <= next_pop_sr[7:0];
            o_res.pc_load    <= (cur_cmd != CMD_POP);
            o_res.pc         <= (cur_cmd == CMD_INT_RET) ? next_pop_sr[15:0] :
                                {next_pop_sr[15:8], next_pop_sr[7:0]};
            o_res.flags_load <= (cur_cmd == CMD_INT_RET);
            o_res.flags      <= next_pop_sr[23:16];
            state            <= ST_IDLE;
          end
          else
            state <= ST_POP_RD;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: testbench/oas_mem_model.sv */
// behavioural register file and program memory facing the unit
module oas_mem_model
  import oas_pkg::*;
(
  input  wire logic              i_clk,
  input  wire oas_pkg::oas_stk_t i_stk,
  input  wire oas_pkg::oas_pm_t  i_pm,
  output logic [7:0]             o_stk_rdata,
  output logic [7:0]             o_pm_rdata
);
  logic [7:0] regs [0:65535];

  initial
  begin
    o_stk_rdata = 8'h3c;
    o_pm_rdata  = 8'hc3;
  end

  always @(posedge i_clk)
  begin
    if (i_stk.we === 1'b1)
      regs[i_stk.addr] <= i_stk.wdata;
  end

  // read data valid one cycle, a changing pattern otherwise
  always @(posedge i_clk)
  begin
    o_stk_rdata <= (i_stk.re === 1'b1) ? regs[i_stk.addr] : ~o_stk_rdata;
    o_pm_rdata  <= (i_pm.re === 1'b1) ? i_pm.addr[7:0] + 8'h30 : ~o_pm_rdata;
  end
endmodule

/* File: testbench/oas_addr_unit_properties.sv */
// port assertions of the operand address and stack unit
module oas_addr_unit_props
  import oas_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_ce,
  input wire logic              i_req_valid,
  input wire oas_pkg::oas_req_t i_req,
  input wire logic              o_req_ready,
  input wire oas_pkg::oas_res_t o_res,
  input wire oas_pkg::oas_stk_t o_stk
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // =====================================================================
  // expected sums
  logic        take;
  logic        ea_take;
  logic [7:0]  idx_sum;
  logic [15:0] short_sum;
  logic [15:0] long_sum;
  logic [15:0] rel_sum;
  assign take      = i_req_valid && o_req_ready && i_ce;
  assign ea_take   = take && i_req.cmd == CMD_EA;
  assign idx_sum   = i_req.opnd + i_req.data;
  assign short_sum = i_req.base + {{8{i_req.opnd[7]}}, i_req.opnd};
  assign long_sum  = i_req.base + i_req.word;
  assign rel_sum   = i_req.pc + {{8{i_req.opnd[7]}}, i_req.opnd};

  // =====================================================================
  // assertions
  wr_decode_a: assert property (
    ea_take && i_req.mode == MD_REG && i_req.opnd[7:4] == WR_PREFIX |=> o_res.valid
    && o_res.space == SPC_REG_SET1 && o_res.addr[2:0] == $past(i_req.opnd[2:0]))
    else $error("working register decode wrong");
  reg_ind_a: assert property (
    ea_take && i_req.mode == MD_REG_IND |=> o_res.addr[7:0] == $past(i_req.data)
    && (o_res.space == SPC_REG_SET2) == ($past(i_req.data) >= UPPER_SET_BASE))
    else $error("indirect register address wrong");
  idx_reg_a: assert property (
    ea_take && i_req.mode == MD_IDX_REG |=> o_res.addr[7:0] == $past(idx_sum)
    && (o_res.space == SPC_REG_SET2) == ($past(idx_sum) >= UPPER_SET_BASE))
    else $error("indexed register address wrong");
  long_idx_a: assert property (
    ea_take && i_req.mode == MD_IDX_LONG |=> o_res.addr == $past(long_sum))
    else $error("long index address wrong");
  short_idx_a: assert property (
    ea_take && i_req.mode == MD_IDX_SHORT |=> o_res.addr == $past(short_sum))
    else $error("short index address wrong");
  abs_addr_a: assert property (
    ea_take && i_req.mode == MD_ABS |=> o_res.addr == $past(i_req.word))
    else $error("absolute address wrong");
  rel_addr_a: assert property (
    ea_take && i_req.mode == MD_REL |=> o_res.addr == $past(rel_sum))
    else $error("relative address wrong");
  imm_word_a: assert property (
    ea_take && i_req.mode == MD_IMM_WORD |=> o_res.valid && o_res.value == $past(i_req.word))
    else $error("immediate value wrong");
  push_write_a: assert property (
    take && i_req.cmd == CMD_PUSH |=> !o_stk.we ##1 o_stk.we
    && o_stk.wdata == $past(i_req.data, 2))
    else $error("push write wrong");
  call_pc_a: assert property (
    take && i_req.cmd == CMD_CALL && i_req.mode == MD_ABS |-> ##3 o_res.valid
    && o_res.pc_load && o_res.pc == $past(i_req.word, 3))
    else $error("call target wrong");
endmodule

bind oas_addr_unit oas_addr_unit_props u_props (
  .i_clk       (i_clk),
  .i_rst       (i_rst),
  .i_ce        (i_ce),
  .i_req_valid (i_req_valid),
  .i_req       (i_req),
  .o_req_ready (o_req_ready),
  .o_res       (o_res),
  .o_stk       (o_stk)
);

/* File: testbench/oas_addr_unit_tb.sv */
// self-checking bench for the operand address and stack unit
module oas_addr_unit_tb
  import oas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_SLICE1 = {2'b00, IDX_SLICE_FIRST, 2'b00};
  localparam logic [11:0] A_SLICE2 = {2'b00, IDX_SLICE_SECOND, 2'b00};
  localparam logic [11:0] A_STK_HI = {2'b00, IDX_STACK_HIGH, 2'b00};
  localparam logic [11:0] A_STK_LO = {2'b00, IDX_STACK_LOW, 2'b00};
  logic        i_clk       = 1'b0;
  logic        i_rst       = 1'b1;
  logic        i_ce        = 1'b1;
  logic        i_psel      = 1'b0;
  logic        i_penable   = 1'b0;
  logic        i_pwrite    = 1'b0;
  logic [11:0] i_paddr     = 12'h000;
  logic [31:0] i_pwdata    = 32'h0000_0000;
  logic        i_req_valid = 1'b0;
  oas_req_t    i_req       = '0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_req_ready;
  oas_res_t    o_res;
  oas_res_t    res;
  oas_stk_t    o_stk;
  oas_stk_t    stk;
  oas_pm_t     o_pm;
  logic [7:0]  i_stk_rdata;
  logic [7:0]  i_pm_rdata;
  logic [31:0] rd;
  logic        er;
  int          mismatches  = 0;
  int          n_checks    = 0;

  always #20 i_clk = ~i_clk;

  oas_addr_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_res(o_res),
    .o_stk(o_stk), .i_stk_rdata(i_stk_rdata), .o_pm(o_pm), .i_pm_rdata(i_pm_rdata));
  oas_mem_model u_mem (.i_clk(i_clk), .i_stk(o_stk), .i_pm(o_pm),
    .o_stk_rdata(i_stk_rdata), .o_pm_rdata(i_pm_rdata));

  // =====================================================================
  // shared tasks
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= {24'h00_0000, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rdchk(logic [11:0] a, logic [7:0] e, string what);
    apb(1'b0, a, 8'h00);
    check(what, {24'h00_0000, e}, rd);
  endtask

  task automatic issue(oas_cmd_t c, oas_mode_t m, logic [7:0] op, logic [7:0] d,
                       logic [15:0] b, logic [15:0] w, logic [15:0] pc, logic [7:0] f);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req       <= '{cmd: c, mode: m, ext: 1'b1, opnd: op, word: w, base: b, data: d,
                     pc: pc, flags: f};
    do @(negedge i_clk); while (o_req_ready !== 1'b1);
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    res = '0;
    for (int k = 0; k < 20 && res.valid !== 1'b1; k++)
    begin
      @(negedge i_clk);
      res = o_res;
      stk = o_stk;
    end
    check("res_valid", 1, res.valid);
  endtask

  task automatic ea(oas_mode_t m, logic [7:0] op, logic [7:0] d, logic [15:0] b,
                    logic [15:0] w, logic [15:0] e, oas_space_t s);
    issue(CMD_EA, m, op, d, b, w, 16'h0100, 8'h00);
    check("ea_result", e, (m inside {MD_IMM_BYTE, MD_IMM_WORD}) ? res.value : res.addr);
    check("ea_space", s, res.space);
  endtask

  // =====================================================================
  // scenarios
  task automatic t_regs();
    rdchk(A_SLICE1, 8'hc0, "slice_pointer_first");
    rdchk(A_SLICE2, 8'hc8, "slice_pointer_second");
    apb(1'b0, 12'h000, 8'h00);
    check("pslverr", 1, er);
    apb(1'b1, A_STK_HI, 8'h12);
    apb(1'b1, A_STK_LO, 8'h34);
    rdchk(A_STK_HI, 8'h12, "stack_pointer_high");
    rdchk(A_STK_LO, 8'h34, "stack_pointer_low");
  endtask

  task automatic t_modes();
    apb(1'b1, A_SLICE2, 8'ha8);
    ea(MD_REG, 8'hcb, 8'h00, 16'h0, 16'h0, 16'h00ab, SPC_REG_SET1);
    ea(MD_REG, 8'hc3, 8'h00, 16'h0, 16'h0, 16'h00c3, SPC_REG_SET1);
    ea(MD_REG, 8'h45, 8'h00, 16'h0, 16'h0, 16'h0045, SPC_REG_SET1);
    ea(MD_REG_IND, 8'h00, 8'h40, 16'h0, 16'h0, 16'h0040, SPC_REG_SET1);
    ea(MD_REG_IND, 8'h00, 8'hd0, 16'h0, 16'h0, 16'h00d0, SPC_REG_SET2);
    ea(MD_PAIR_IND, 8'h00, 8'h00, 16'h1234, 16'h0, 16'h1234, SPC_EXT);
    ea(MD_IDX_REG, 8'h10, 8'h20, 16'h0, 16'h0, 16'h0030, SPC_REG_SET1);
    ea(MD_IDX_REG, 8'hb0, 8'h20, 16'h0, 16'h0, 16'h00d0, SPC_REG_SET2);
    ea(MD_IDX_REG, 8'hf0, 8'h20, 16'h0, 16'h0, 16'h0010, SPC_REG_SET1);
    ea(MD_IDX_LONG, 8'h00, 8'h00, 16'h1000, 16'h0234, 16'h1234, SPC_EXT);
    ea(MD_IDX_SHORT, 8'h80, 8'h00, 16'h1000, 16'h0, 16'h0f80, SPC_EXT);
    ea(MD_ABS, 8'h00, 8'h00, 16'h0, 16'hbeef, 16'hbeef, SPC_EXT);
    ea(MD_REL, 8'hfe, 8'h00, 16'h0, 16'h0, 16'h00fe, SPC_PROG);
    ea(MD_REL, 8'h7f, 8'h00, 16'h0, 16'h0, 16'h017f, SPC_PROG);
    ea(MD_IMM_BYTE, 8'h9c, 8'h00, 16'h0, 16'h0, 16'h009c, SPC_VALUE);
    ea(MD_IMM_WORD, 8'h00, 8'h00, 16'h0, 16'h5aa5, 16'h5aa5, SPC_VALUE);
  endtask

  task automatic t_wrap();
    apb(1'b1, A_STK_HI, 8'h01);
    apb(1'b1, A_STK_LO, 8'h00);
    issue(CMD_PUSH, MD_REG, 8'h00, 8'h5a, 16'h0, 16'h0, 16'h0, 8'h00);
    check("push_addr", 16'h00ff, stk.addr);
    check("push_data", 8'h5a, stk.wdata);
    rdchk(A_STK_HI, 8'h00, "stack_pointer_high");
    issue(CMD_POP, MD_REG, 8'h00, 8'h00, 16'h0, 16'h0, 16'h0, 8'h00);
    check("pop_data", 8'h5a, res.data_load ? res.data : 8'h00);
    rdchk(A_STK_HI, 8'h01, "stack_pointer_high");
    rdchk(A_STK_LO, 8'h00, "stack_pointer_low");
  endtask

  task automatic t_calls();
    apb(1'b1, A_STK_HI, 8'h77);
    apb(1'b1, A_STK_LO, 8'hff);
    issue(CMD_CALL, MD_ABS, 8'h00, 8'h00, 16'h0, 16'h2345, 16'h1122, 8'h00);
    check("call_pc", 16'h2345, res.pc);
    issue(CMD_CALL, MD_MEM_IND, 8'h20, 8'h00, 16'h0, 16'h0, 16'h3000, 8'h00);
    check("ind_call_pc", 16'h5051, res.pc);
    issue(CMD_RET, MD_REG, 8'h00, 8'h00, 16'h0, 16'h0, 16'h0, 8'h00);
    check("ret_pc", 16'h3000, res.pc_load ? res.pc : 16'h0);
    issue(CMD_RET, MD_REG, 8'h00, 8'h00, 16'h0, 16'h0, 16'h0, 8'h00);
    check("ret_pc", 16'h1122, res.pc);
    issue(CMD_INTR, MD_REG, 8'h00, 8'h00, 16'h0, 16'h0010, 16'h3344, 8'ha5);
    check("intr_pc", 16'h0010, res.pc);
    issue(CMD_INT_RET, MD_REG, 8'h00, 8'h00, 16'h0, 16'h0, 16'h0, 8'h00);
    check("intret_pc", 16'h3344, res.pc);
    check("intret_flags", 8'ha5, res.flags_load ? res.flags : 8'h00);
    rdchk(A_STK_LO, 8'hff, "stack_pointer_low");
    rdchk(A_STK_HI, 8'h77, "stack_pointer_high");
  endtask

  // write stretched by a clock-enable hold
  task automatic t_hold();
    fork
      apb(1'b1, A_SLICE1, 8'h48);
      begin
        repeat (2) @(posedge i_clk);
        i_ce <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("pready_held", 0, o_pready);
        @(posedge i_clk);
        i_ce <= 1'b1;
      end
    join
    rdchk(A_SLICE1, 8'h48, "slice_pointer_first");
  endtask

  // second reset: first pointer back to common block, stack pointer kept
  task automatic t_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk(A_SLICE1, 8'hc0, "slice_pointer_first");
    rdchk(A_STK_LO, 8'hff, "stack_pointer_low");
    rdchk(A_STK_HI, 8'h77, "stack_pointer_high");
  endtask

  // =====================================================================
  // run control
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_modes();
    t_wrap();
    t_calls();
    t_hold();
    t_reset();
    report_and_stop();
  end

  initial
  begin
    #800000;
    mismatches++;
    report_and_stop();
  end
endmodule
